// file: logic/adsq_pkg.sv
// Register map, field layout and state encoding of the converter sequencer
package adsq_pkg;
  // Printed offsets serve as Avalon word indices; byte address is four times these
  localparam logic [15:0] OFF_RESULT = 16'h5380;
  localparam logic [15:0] OFF_TRIGGER = 16'h5382;
  localparam logic [15:0] OFF_CONTROL = 16'h5384;
  localparam logic [15:0] OFF_CLOCK = 16'h5386;
  // Trigger/channel select fields
  localparam int TRG_END_LSB = 11;
  localparam int TRG_START_LSB = 8;
  localparam int TRG_ALIGN_BIT = 7;
  localparam int TRG_REPEAT_BIT = 6;
  localparam int TRG_SRC_LSB = 4;
  localparam int TRG_SAMPLE_LSB = 0;
  localparam logic [15:0] TRG_WMASK = 16'h3FF7;
  localparam logic [15:0] TRG_RESET = 16'h0007;
  // Control/status fields
  localparam int CTL_CHAN_LSB = 12;
  localparam int CTL_BUSY_BIT = 10;
  localparam int CTL_OVR_BIT = 9;
  localparam int CTL_DONE_BIT = 8;
  localparam int CTL_OVR_IE_BIT = 5;
  localparam int CTL_DONE_IE_BIT = 4;
  localparam int CTL_GO_BIT = 1;
  localparam int CTL_EN_BIT = 0;
  // Clock control fields
  localparam logic [15:0] CLK_WMASK = 16'h000F;
  localparam logic [15:0] CLK_RESET = 16'h0000;
  localparam logic [3:0] CLK_DIV_RESERVED = 4'hF;
  localparam logic [3:0] CLK_DIV_MAX = 4'hE;
  // Trigger sources
  localparam logic [1:0] SRC_SOFTWARE = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  // Sampling lasts field value plus this many conversion-clock cycles
  localparam logic [3:0] SAMPLE_EXTRA = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } adsq_state_t;
endpackage : adsq_pkg

// file: logic/adsq_top.sv
// Register file, trigger selection and channel sequencer of the converter
// Operation
// - One interrupt line serves both completion and overwrite causes.
// - Finished conversion loads result, sets done_flag, interrupts if enabled.
// - Reading the result register clears done_flag.
// - Finish while done_flag set overwrites result, sets overrun_flag, may interrupt.
// - overrun_flag clears only on writing one; writing zero does nothing.
// - Overwrite also sets done_flag for the new result.
// - Four registers at offsets two apart: result, trigger, control, clock.
// - Result register is read-only; writes are ignored.
// - result_align_left picks bits 15..6, else bits 9..0; rest zero.
// - Channels start_channel to end_channel converted in turn per trigger.
// - repeat_mode loops the range until stopped, else one pass.
// - Only the selected trigger source starts; code 2 is reserved.
// - External source starts on a falling edge of external_trigger_n.
// - Sampling lasts sample_cycles plus two conversion-clock cycles.
// - current_channel reports the channel in progress, resets to zero.
// - busy_status rises at accepted trigger, falls when sequence ends.
// - Reserved bits are written as zero and read back as zero.
// - Writing one to conversion_go starts; hardware sets it on other triggers.
// - One-shot clears conversion_go at range end; writing zero aborts.
// - converter_enable low blocks triggers but not a running sequence.
// - Overwrite error does not stop a repeating sequence.
module adsq_top #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer_underflow,
  input wire logic external_trigger_n,
  output logic adc_sample,
  output logic adc_start,
  output logic [2:0] adc_channel,
  input wire logic [9:0] adc_result,
  input wire logic adc_done,
  output logic irq
);
  import adsq_pkg::*;

  if (ADDR_W < 15) begin : g_addr_check
    $error("adsq_top: ADDR_W too small for register offsets");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [15:0] wmask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & wmask;
  endfunction : merge16

  logic wait_reg;
  logic [31:0] readdata_reg;
  logic [15:0] trg_reg;
  logic [15:0] clk_reg;
  logic en_reg;
  logic done_ie_reg;
  logic ovr_ie_reg;
  logic run_reg;
  logic done_reg;
  logic done_next;
  logic ovr_reg;
  logic ovr_next;
  logic load_last_reg;
  logic [15:0] res_reg;
  logic [2:0] cur_ch_reg;
  adsq_state_t st_reg;
  logic [14:0] div_cnt_reg;
  logic [3:0] samp_cnt_reg;
  logic ext_prev_reg;
  logic start_reg;
  logic irq_reg;

  logic req;
  logic rd_commit;
  logic wr_commit;
  logic sel_res;
  logic sel_trg;
  logic sel_ctl;
  logic sel_clk;
  logic go_write1;
  logic go_write0;
  logic ovr_clear;
  logic done_clear;
  logic accept;
  logic abort;
  logic load_event;
  logic last_ch;
  logic tick;
  logic sample_end;
  logic [3:0] addf_eff;
  logic [14:0] div_lim;
  logic [2:0] end_ch;
  logic [2:0] start_ch;
  logic [1:0] src;
  logic [3:0] samp_target;
  logic ext_fall;

  // Bus decode; access commits at the edge where waitrequest is seen low
  assign req = avs_read | avs_write;
  assign rd_commit = avs_read & ~wait_reg;
  assign wr_commit = avs_write & ~wait_reg;
  assign sel_res = avs_address == ADDR_W'(OFF_RESULT);
  assign sel_trg = avs_address == ADDR_W'(OFF_TRIGGER);
  assign sel_ctl = avs_address == ADDR_W'(OFF_CONTROL);
  assign sel_clk = avs_address == ADDR_W'(OFF_CLOCK);
  assign go_write1 = wr_commit & sel_ctl & avs_byteenable[0] & avs_writedata[CTL_GO_BIT];
  assign go_write0 = wr_commit & sel_ctl & avs_byteenable[0] & ~avs_writedata[CTL_GO_BIT];
  assign ovr_clear = wr_commit & sel_ctl & avs_byteenable[1] & avs_writedata[CTL_OVR_BIT];
  // A result that landed while the read was being prepared is not covered by it
  assign done_clear = rd_commit & sel_res & ~load_last_reg;

  assign end_ch = trg_reg[TRG_END_LSB +: 3];
  assign start_ch = trg_reg[TRG_START_LSB +: 3];
  assign src = trg_reg[TRG_SRC_LSB +: 2];
  assign samp_target = {1'b0, trg_reg[TRG_SAMPLE_LSB +: 3]} + SAMPLE_EXTRA - 4'h1;
  assign addf_eff = (clk_reg[3:0] == CLK_DIV_RESERVED) ? CLK_DIV_MAX : clk_reg[3:0];
  assign div_lim = 15'((16'h0002 << addf_eff) - 16'h0001);
  assign tick = div_cnt_reg == div_lim;

  // Inputs are synchronous, so one stage of history suffices for the edge
  assign ext_fall = ext_prev_reg & ~external_trigger_n;
  // Enable is the stored bit, so enabling and starting in one access does not start;
  // software must enable first, which also keeps a half-configured unit from running
  assign accept = en_reg & ~run_reg & ((src == SRC_SOFTWARE & go_write1)
                  | (src == SRC_TIMER & timer_underflow) | (src == SRC_EXTERNAL & ext_fall));
  assign abort = go_write0 & run_reg;
  assign load_event = (st_reg == ST_CONVERT) & adc_done & ~abort;
  assign last_ch = (cur_ch_reg == end_ch) | (start_ch > end_ch);
  assign sample_end = (st_reg == ST_SAMPLE) & tick & (samp_cnt_reg == samp_target);

  // Set beats clear on both flags
  always_comb begin
    done_next = done_reg;
    if (done_clear) begin
      done_next = 1'b0;
    end
    if (load_event) begin
      done_next = 1'b1;
    end
    ovr_next = ovr_reg;
    if (ovr_clear) begin
      ovr_next = 1'b0;
    end
    if (load_event & done_reg & ~done_clear) begin
      ovr_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read & wait_reg) begin
      readdata_reg <= 32'h0000_0000;
      if (sel_res) begin
        readdata_reg[15:0] <= res_reg;
      end else if (sel_trg) begin
        readdata_reg[15:0] <= trg_reg;
      end else if (sel_ctl) begin
        readdata_reg[CTL_CHAN_LSB +: 3] <= cur_ch_reg;
        readdata_reg[CTL_BUSY_BIT] <= run_reg;
        readdata_reg[CTL_OVR_BIT] <= ovr_reg;
        readdata_reg[CTL_DONE_BIT] <= done_reg;
        readdata_reg[CTL_OVR_IE_BIT] <= ovr_ie_reg;
        readdata_reg[CTL_DONE_IE_BIT] <= done_ie_reg;
        readdata_reg[CTL_GO_BIT] <= run_reg;
        readdata_reg[CTL_EN_BIT] <= en_reg;
      end else if (sel_clk) begin
        readdata_reg[15:0] <= clk_reg;
      end
    end
  end

  // Configuration registers; no branch for the result offset, so writes there vanish
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trg_reg <= TRG_RESET;
      clk_reg <= CLK_RESET;
      en_reg <= 1'b0;
      done_ie_reg <= 1'b0;
      ovr_ie_reg <= 1'b0;
    end else if (wr_commit) begin
      if (sel_trg) begin
        trg_reg <= merge16(trg_reg, avs_writedata, avs_byteenable, TRG_WMASK);
      end
      if (sel_clk) begin
        clk_reg <= merge16(clk_reg, avs_writedata, avs_byteenable, CLK_WMASK);
      end
      if (sel_ctl & avs_byteenable[0]) begin
        en_reg <= avs_writedata[CTL_EN_BIT];
        done_ie_reg <= avs_writedata[CTL_DONE_IE_BIT];
        ovr_ie_reg <= avs_writedata[CTL_OVR_IE_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      done_reg <= 1'b0;
      ovr_reg <= 1'b0;
      load_last_reg <= 1'b0;
      res_reg <= 16'h0000;
      irq_reg <= 1'b0;
      ext_prev_reg <= 1'b1;
    end else begin
      done_reg <= done_next;
      ovr_reg <= ovr_next;
      load_last_reg <= load_event;
      ext_prev_reg <= external_trigger_n;
      irq_reg <= (done_next & done_ie_reg) | (ovr_next & ovr_ie_reg);
      if (load_event) begin
        res_reg <= trg_reg[TRG_ALIGN_BIT] ? {adc_result, 6'h00} : {6'h00, adc_result};
      end
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= ST_IDLE;
      run_reg <= 1'b0;
      cur_ch_reg <= 3'h0;
      div_cnt_reg <= 15'h0000;
      samp_cnt_reg <= 4'h0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      div_cnt_reg <= tick ? 15'h0000 : div_cnt_reg + 15'h0001;
      case (st_reg)
        ST_IDLE: begin
          div_cnt_reg <= 15'h0000;
          if (accept) begin
            st_reg <= ST_SAMPLE;
            run_reg <= 1'b1;
            cur_ch_reg <= start_ch;
            samp_cnt_reg <= 4'h0;
          end
        end
        ST_SAMPLE: begin
          if (abort) begin
            st_reg <= ST_IDLE;
            run_reg <= 1'b0;
          end else if (sample_end) begin
            st_reg <= ST_CONVERT;
            start_reg <= 1'b1;
          end else if (tick) begin
            samp_cnt_reg <= samp_cnt_reg + 4'h1;
          end
        end
        ST_CONVERT: begin
          if (abort) begin
            st_reg <= ST_IDLE;
            run_reg <= 1'b0;
          end else if (adc_done) begin
            div_cnt_reg <= 15'h0000;
            samp_cnt_reg <= 4'h0;
            if (last_ch & ~trg_reg[TRG_REPEAT_BIT]) begin
              st_reg <= ST_IDLE;
              run_reg <= 1'b0;
            end else begin
              st_reg <= ST_SAMPLE;
              cur_ch_reg <= last_ch ? start_ch : cur_ch_reg + 3'h1;
            end
          end
        end
        default: begin
          st_reg <= ST_IDLE;
          run_reg <= 1'b0;
        end
      endcase
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = readdata_reg;
  // One-hot code: the sampling bit of the state register drives the pin directly
  assign adc_sample = st_reg[1];
  assign adc_start = start_reg;
  assign adc_channel = cur_ch_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_accept;
    accept;
  endsequence
  sequence s_running;
    run_reg && st_reg == ST_SAMPLE && cur_ch_reg == start_ch;
  endsequence
  sequence s_load_while_full;
    load_event && done_reg && !done_clear;
  endsequence

  property p_irq_done;
    load_event && done_ie_reg |=> irq && done_reg;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("completion did not raise irq");
  property p_done_clear;
    done_clear && !load_event |=> !done_reg;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("result read left done set");
  property p_ovr_set;
    s_load_while_full |=> ovr_reg && done_reg && (irq || !$past(ovr_ie_reg));
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overwrite not flagged");
  property p_ovr_hold;
    ovr_reg && !ovr_clear |=> ovr_reg;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun flag dropped");
  property p_res_ro;
    wr_commit && sel_res && !load_event |=> $stable(res_reg);
  endproperty
  a_res_ro: assert property (p_res_ro) else $error("result register written");
  property p_align;
    load_event && trg_reg[TRG_ALIGN_BIT] |=> res_reg[5:0] == 6'h00 && res_reg[15:6] == $past(adc_result);
  endproperty
  a_align: assert property (p_align) else $error("left alignment wrong");
  property p_start;
    s_accept |=> s_running;
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start sequence");
  property p_sample_len;
    sample_end && !abort |=> st_reg == ST_CONVERT && adc_start ##1 !adc_start;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling end wrong");
  property p_disabled;
    !en_reg && !run_reg |=> !run_reg;
  endproperty
  a_disabled: assert property (p_disabled) else $error("trigger taken while disabled");
  property p_abort;
    abort |=> !run_reg && st_reg == ST_IDLE && $stable(res_reg);
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");
  property p_oneshot;
    load_event && last_ch && !trg_reg[TRG_REPEAT_BIT] |=> !run_reg ##1 !adc_start;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");
  property p_repeat;
    load_event && trg_reg[TRG_REPEAT_BIT] |=> run_reg && st_reg == ST_SAMPLE;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat stopped");
  property p_ext;
    ext_fall && src == SRC_EXTERNAL && en_reg && !run_reg |=> run_reg;
  endproperty
  a_ext: assert property (p_ext) else $error("falling edge ignored");
  property p_next_ch;
    load_event && !last_ch |=> cur_ch_reg == $past(cur_ch_reg) + 3'h1;
  endproperty
  a_next_ch: assert property (p_next_ch) else $error("channel did not advance");
endmodule : adsq_top

// file: verif/adsq_macro_model.sv
// Behavioural model of the analog converter macro
module adsq_macro_model #(
  parameter int CONV_CYCLES = 3
) (
  input wire logic sys_clk,
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  output logic [9:0] adc_result,
  output logic adc_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic [2:0] ch = 3'h0;
  initial begin
    adc_result = 10'h000;
    adc_done = 1'b0;
  end
  // Result only valid with done; otherwise it toggles so stale data never looks good
  always @(posedge sys_clk) begin
    adc_done <= 1'b0;
    adc_result <= ~adc_result;
    if (adc_start === 1'b1) begin
      cnt = CONV_CYCLES;
      ch = adc_channel;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        adc_done <= 1'b1;
        adc_result <= {ch, 7'h2A};
      end
    end
  end
endmodule : adsq_macro_model

// file: verif/tb_top.sv
// Self-checking bench for the converter sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import adsq_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timer_underflow = 1'b0;
  logic external_trigger_n = 1'b1;
  logic adc_sample, adc_start, adc_done, irq;
  logic [2:0] adc_channel;
  logic [9:0] adc_result;
  logic [15:0] rd;
  int miscompares = 0;
  int num_checks = 0;
  int samp_len = 0;
  int samp_cnt = 0;

  adsq_top dut (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_underflow, .external_trigger_n,
    .adc_sample, .adc_start, .adc_channel, .adc_result, .adc_done, .irq);
  adsq_macro_model macro (.sys_clk, .adc_start, .adc_channel, .adc_result, .adc_done);

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // Length of the last sampling phase, in system cycles
  always @(posedge sys_clk) begin
    if (adc_sample === 1'b1) begin
      samp_cnt <= samp_cnt + 1;
    end else if (samp_cnt != 0) begin
      samp_len <= samp_cnt;
      samp_cnt <= 0;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  // Entered just after a rising edge; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rchk(input string what, input logic [15:0] a, input logic [15:0] m, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(what, exp, rd & m);
  endtask : rchk

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_CONTROL, 16'h0000);
      n++;
    end while (rd[CTL_GO_BIT] !== 1'b0 && n < 200);
    chk("go at end", 16'h0000, {15'h0000, rd[CTL_GO_BIT]});
  endtask : wait_idle

  task automatic pulse_timer();
    timer_underflow <= 1'b1;
    @(posedge sys_clk);
    timer_underflow <= 1'b0;
    repeat (60) @(posedge sys_clk);
  endtask : pulse_timer

  task automatic fall_ext();
    external_trigger_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    external_trigger_n <= 1'b1;
    @(posedge sys_clk);
  endtask : fall_ext

  task automatic t_regs();
    rchk("result reset", OFF_RESULT, 16'hFFFF, 16'h0000);
    rchk("trigger reset", OFF_TRIGGER, 16'hFFFF, 16'h0007);
    rchk("control reset", OFF_CONTROL, 16'hFFFF, 16'h0000);
    rchk("clock reset", OFF_CLOCK, 16'hFFFF, 16'h0000);
    rchk("unmapped", 16'h5388, 16'hFFFF, 16'h0000);
    bus(1'b1, OFF_TRIGGER, 16'hFFFF);
    rchk("trigger reserved", OFF_TRIGGER, 16'hFFFF, 16'h3FF7);
    bus(1'b1, OFF_CLOCK, 16'hFFFF);
    rchk("clock reserved", OFF_CLOCK, 16'hFFFF, 16'h000F);
    bus(1'b1, OFF_CLOCK, 16'h0000);
    bus(1'b1, OFF_RESULT, 16'h1234);
    rchk("result write", OFF_RESULT, 16'hFFFF, 16'h0000);
  endtask : t_regs

  task automatic t_oneshot();
    bus(1'b1, OFF_TRIGGER, 16'h1100);
    bus(1'b1, OFF_CONTROL, 16'h0011);
    bus(1'b1, OFF_CONTROL, 16'h0013);
    wait_idle();
    chk("flags after pass", 16'h0311, rd & 16'h0733);
    chk("sample length", 16'd4, 16'(samp_len));
    chk("irq on done", 16'h0001, {15'h0000, irq});
    rchk("last channel", OFF_RESULT, 16'hFFFF, 16'h012A);
    rchk("done cleared", OFF_CONTROL, 16'h0733, 16'h0211);
    chk("irq dropped", 16'h0000, {15'h0000, irq});
    bus(1'b1, OFF_CONTROL, 16'h0011);
    rchk("overrun kept", OFF_CONTROL, 16'h0733, 16'h0211);
    bus(1'b1, OFF_CONTROL, 16'h0211);
    rchk("overrun cleared", OFF_CONTROL, 16'h0733, 16'h0011);
  endtask : t_oneshot

  task automatic t_repeat();
    bus(1'b1, OFF_TRIGGER, 16'h2DD0);
    bus(1'b1, OFF_CONTROL, 16'h0021);
    pulse_timer();
    repeat (20) @(posedge sys_clk);
    rchk("repeat running", OFF_CONTROL, 16'h7723, 16'h5723);
    chk("irq on overrun", 16'h0001, {15'h0000, irq});
    rchk("left aligned", OFF_RESULT, 16'hFFFF, 16'hAA80);
    bus(1'b1, OFF_CONTROL, 16'h0021);
    rchk("aborted", OFF_CONTROL, 16'h0402, 16'h0000);
    repeat (40) @(posedge sys_clk);
    rchk("stays stopped", OFF_CONTROL, 16'h0402, 16'h0000);
  endtask : t_repeat

  task automatic t_sources();
    bus(1'b0, OFF_RESULT, 16'h0000);
    bus(1'b1, OFF_CONTROL, 16'h0200);
    bus(1'b1, OFF_TRIGGER, 16'h0027);
    bus(1'b1, OFF_CONTROL, 16'h0001);
    bus(1'b1, OFF_CONTROL, 16'h0003);
    fall_ext();
    pulse_timer();
    rchk("reserved source", OFF_CONTROL, 16'h0402, 16'h0000);
    bus(1'b1, OFF_TRIGGER, 16'h0037);
    bus(1'b1, OFF_CONTROL, 16'h0001);
    pulse_timer();
    rchk("timer ignored", OFF_CONTROL, 16'h0302, 16'h0000);
    bus(1'b1, OFF_CLOCK, 16'h0001);
    fall_ext();
    wait_idle();
    chk("external done", 16'h0100, rd & 16'h0302);
    chk("sample length max", 16'd36, 16'(samp_len));
    rchk("external result", OFF_RESULT, 16'hFFFF, 16'h002A);
    bus(1'b1, OFF_CONTROL, 16'h0000);
    fall_ext();
    repeat (60) @(posedge sys_clk);
    rchk("disabled ignores", OFF_CONTROL, 16'h0102, 16'h0000);
  endtask : t_sources

  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_oneshot();
    t_repeat();
    t_sources();
    results();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    results();
  end
endmodule : tb_top
